// file: rtl/uesc_cfg.svh
// Constants of the endpoint status and buffer control block.
`ifndef UESC_CFG_SVH
`define UESC_CFG_SVH

// ==========================================================
// Command code groups (upper nibble) and the single codes.
`define UESC_GRP_STALL    4'h4
`define UESC_GRP_READ     4'h5
`define UESC_GRP_VALIDATE 4'h6
`define UESC_GRP_CLEAR    4'h7
`define UESC_GRP_UNSTALL  4'h8
`define UESC_GRP_CHECK    4'hD
`define UESC_CODE_ACK     8'hF4

// ==========================================================
// Endpoint numbering in the low nibble.
`define UESC_EP_CTRL_OUT  4'h0
`define UESC_EP_CTRL_IN   4'h1
`define UESC_EP_COUNT     16

// ==========================================================
// Status byte field positions and reset value.
`define UESC_BIT_HALT     7
`define UESC_BIT_FULL1    6
`define UESC_BIT_FULL0    5
`define UESC_BIT_TOGGLE   4
`define UESC_BIT_CLOBBER  3
`define UESC_BIT_SETUP    2
`define UESC_BIT_HOST_CPU_BUFFER_SELECT   1
`define UESC_BIT_RSVD     0
`define UESC_STATUS_RST   8'h00

`endif

// file: rtl/uesc_pkg.sv
// Types shared by the endpoint status and buffer control block.
package uesc_pkg;

  // Decoded microcontroller command.
  typedef enum logic [2:0] {
    UESC_OP_NONE,
    UESC_OP_READ,
    UESC_OP_CHECK,
    UESC_OP_STALL,
    UESC_OP_UNSTALL,
    UESC_OP_VALIDATE,
    UESC_OP_CLEAR,
    UESC_OP_ACK
  } uesc_op_t;

  // Completed packet report from the serial engine.
  typedef struct packed {
    logic       done;
    logic [3:0] ep;
    logic       pid;
  } uesc_pkt_t;

endpackage

// file: rtl/uesc_cmd_decode.sv
// Command code classifier for the endpoint status block.
`timescale 1ns/1ns
`include "uesc_cfg.svh"

module uesc_cmd_decode (
  // Command phase byte.
  input  wire logic [7:0]     cmd_code,
  // Classified command.
  output uesc_pkg::uesc_op_t  op,
  output logic [3:0]          ep
);

  logic [3:0] grp;
  logic       is_ack;
  logic       valid_ok;
  logic       clear_ok;

  // Validate has no code for endpoint 0, clear none for endpoint 1.
  assign grp      = cmd_code[7:4];
  assign ep       = cmd_code[3:0];
  assign is_ack   = cmd_code == `UESC_CODE_ACK;
  assign valid_ok = ep != `UESC_EP_CTRL_OUT; // R16
  assign clear_ok = ep != `UESC_EP_CTRL_IN;  // R18

  // Group selection.
  assign op = is_ack                                 ? uesc_pkg::UESC_OP_ACK      :
              (grp == `UESC_GRP_READ)                ? uesc_pkg::UESC_OP_READ     : // R1
              (grp == `UESC_GRP_CHECK)               ? uesc_pkg::UESC_OP_CHECK    : // R20
              (grp == `UESC_GRP_STALL)               ? uesc_pkg::UESC_OP_STALL    : // R6
              (grp == `UESC_GRP_UNSTALL)             ? uesc_pkg::UESC_OP_UNSTALL  : // R6
              (grp == `UESC_GRP_VALIDATE && valid_ok) ? uesc_pkg::UESC_OP_VALIDATE :
              (grp == `UESC_GRP_CLEAR && clear_ok)    ? uesc_pkg::UESC_OP_CLEAR    :
                                                       uesc_pkg::UESC_OP_NONE;

endmodule

// file: rtl/uesc_rd_port.sv
// One-byte data phase holder for status and check commands.
`timescale 1ns/1ns
`include "uesc_cfg.svh"

module uesc_rd_port (
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // Load side, from the command phase.
  input  wire logic       load,
  input  wire logic       load_clears,
  input  wire logic [3:0] load_ep,
  input  wire logic [7:0] load_byte,
  // Data phase side.
  input  wire logic       data_rd,
  output logic [7:0]      rd_data,
  output logic            rd_pending,
  output logic            read_done,
  output logic [3:0]      read_ep
);

  typedef enum logic {UESC_RD_IDLE, UESC_RD_ARMED} uesc_rd_state_t;

  uesc_rd_state_t state_reg;
  uesc_rd_state_t state_next;
  logic           clears_reg;
  logic           take;

  // A read consumes the armed byte; a new load re-arms at once.
  assign take       = data_rd && state_reg == UESC_RD_ARMED;
  assign read_done  = take && clears_reg; // R3
  assign rd_pending = state_reg == UESC_RD_ARMED;
  assign state_next = load ? UESC_RD_ARMED : (take ? UESC_RD_IDLE : state_reg);

  // Byte and owner are frozen at command time, so later events do not tear it.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg  <= UESC_RD_IDLE;
      clears_reg <= 1'b0;
      read_ep    <= 4'h0;
      rd_data    <= `UESC_STATUS_RST;
    end else begin
      state_reg <= state_next;
      if (load) begin
        clears_reg <= load_clears;
        read_ep    <= load_ep;
        rd_data    <= load_byte; // R1
      end
    end
  end

endmodule

// file: rtl/uesc_ep_status_ctrl.sv
// Per-endpoint status and buffer control of a full-speed device.
`timescale 1ns/1ns
`include "uesc_cfg.svh"

// Contract
// R1 - Codes 50..5F return the endpoint status byte
// R2 - Low code nibble selects endpoint zero to fifteen
// R3 - Status read clears that endpoint's interrupt bit
// R4 - Status bits read-only, reset to zero
// R5 - Stall sets halted flag, unstall clears it
// R6 - Stall 40..4F, unstall 80..8F, no data
// R7 - SETUP token unstalls a stalled control endpoint
// R8 - Firmware may re-stall after SETUP unstall
// R9 - Unstall reinitialises endpoint, flushes, restarts at DATA0
// R10 - Setup setup_clobbered_flag flag set; cleared by read after write
// R11 - Firmware checks setup_clobbered_flag flag before ack or stall
// R12 - Setup present flag while buffer holds setup
// R13 - Buffer select bit shows microcontroller buffer
// R14 - Full flags show primary and secondary buffer
// R15 - Toggle bit shows present packet data_toggle_flag
// R16 - Validate 61..6F fills the IN buffer
// R17 - Double buffering: validate and clear swap buffers
// R18 - Clear 70, 72..7F empties the OUT buffer
// R19 - Full OUT buffer NAKs until cleared
// R20 - Check D0..DF returns copy, clears nothing
// R21 - After setup, validate and clear wait for ack
// R22 - Reserved bit zero always reads zero
module uesc_ep_status_ctrl (
  // Clock and reset.
  input  wire logic                 sys_clk,
  input  wire logic                 rst_b,
  // Microcontroller command port.
  input  wire logic                 cmd_strobe,
  input  wire logic [7:0]           cmd_code,
  input  wire logic                 data_rd,
  output logic [7:0]                rd_data,
  output logic                      rd_pending,
  // Endpoint configuration from the rest of the device.
  input  wire logic [15:0]          ep_double,
  input  wire logic [15:0]          ep_is_in,
  // Serial engine events.
  input  wire logic                 setup_token,
  input  wire logic                 setup_written,
  input  wire uesc_pkg::uesc_pkt_t  pkt,
  // Answers to the serial engine and interrupt logic.
  output logic [15:0]               ep_nak,
  output logic [15:0]               ep_stalled,
  output logic [15:0]               ep_int_clr,
  output logic                      setup_locked
);

  // ==========================================================
  // Helpers.

  // True when the selected endpoint number is this slot.
  function automatic logic ep_hit(input logic [3:0] sel, input int unsigned idx);
    ep_hit = sel == idx[3:0];
  endfunction

  // Control endpoints are the first two slots.
  function automatic logic is_ctrl(input int unsigned idx);
    is_ctrl = idx < 2;
  endfunction

  // ==========================================================
  // Command phase decode.

  uesc_pkg::uesc_op_t op;
  logic [3:0]         cmd_ep;
  logic               op_read;
  logic               op_check;
  logic               op_stall;
  logic               op_unstall;
  logic               op_validate;
  logic               op_clear;
  logic               op_ack;
  logic [7:0]         sel_status;
  logic               read_done;
  logic [3:0]         read_ep;
  logic [7:0]         status_byte [`UESC_EP_COUNT];
  logic [15:0]        direction_in;

  uesc_cmd_decode u_decode (
    .cmd_code (cmd_code),
    .op       (op),
    .ep       (cmd_ep)
  );

  // Each command acts only in the cycle of its strobe.
  assign op_read     = cmd_strobe && op == uesc_pkg::UESC_OP_READ;
  assign op_check    = cmd_strobe && op == uesc_pkg::UESC_OP_CHECK;
  assign op_stall    = cmd_strobe && op == uesc_pkg::UESC_OP_STALL;
  assign op_unstall  = cmd_strobe && op == uesc_pkg::UESC_OP_UNSTALL;
  assign op_validate = cmd_strobe && op == uesc_pkg::UESC_OP_VALIDATE;
  assign op_clear    = cmd_strobe && op == uesc_pkg::UESC_OP_CLEAR;
  assign op_ack      = cmd_strobe && op == uesc_pkg::UESC_OP_ACK;

  // Endpoint 0 is always OUT and endpoint 1 always IN.
  assign direction_in = {ep_is_in[15:2], 2'b10};

  // The selected status byte feeds both read flavours.
  assign sel_status = status_byte[cmd_ep]; // R2

  // ==========================================================
  // Data phase.

  // The check command loads the same byte but never clears anything.
  uesc_rd_port u_rd_port (
    .sys_clk     (sys_clk),
    .rst_b       (rst_b),
    .load        (op_read || op_check), // R20
    .load_clears (op_read),
    .load_ep     (cmd_ep),
    .load_byte   (sel_status),
    .data_rd     (data_rd),
    .rd_data     (rd_data),
    .rd_pending  (rd_pending),
    .read_done   (read_done),
    .read_ep     (read_ep)
  );

  // ==========================================================
  // Setup lock shared by both control endpoints.

  logic lock_reg;
  logic lock_next;

  // A new setup wins over an acknowledge in the same cycle.
  assign lock_next    = setup_token || (lock_reg && !op_ack); // R21
  assign setup_locked = lock_reg;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_reg <= 1'b0;
    end else begin
      lock_reg <= lock_next;
    end
  end

  // ==========================================================
  // Per-endpoint state.

  genvar gi;
  generate
    for (gi = 0; gi < `UESC_EP_COUNT; gi++) begin : g_ep
      logic       halt_reg;
      logic       halt_next;
      logic [1:0] full_reg;
      logic [1:0] full_next;
      logic       toggle_reg;
      logic       toggle_next;
      logic       clob_reg;
      logic       clob_next;
      logic       setup_reg;
      logic       setup_next;
      logic       cpu_sel_reg;
      logic       cpu_sel_next;
      logic       usb_sel_reg;
      logic       usb_sel_next;
      logic       writing_reg;
      logic       writing_next;
      logic       cmd_here;
      logic       stall_here;
      logic       unstall_here;
      logic       setup_here;
      logic       reinit;
      logic       validate_here;
      logic       clear_here;
      logic       pkt_here;
      logic       read_here;
      logic       clob_set;
      logic       clob_clr;
      logic       written_here;
      logic       locked_here;
      logic       nak_here;

      // Event routing for this slot.
      assign cmd_here      = ep_hit(cmd_ep, gi); // R2
      assign locked_here   = is_ctrl(gi) && lock_reg;
      assign stall_here    = op_stall && cmd_here;
      assign unstall_here  = op_unstall && cmd_here;
      assign setup_here    = setup_token && is_ctrl(gi);
      assign reinit        = unstall_here || setup_here; // R9
      assign validate_here = op_validate && cmd_here && direction_in[gi] && !locked_here; // R21
      assign clear_here    = op_clear && cmd_here && !direction_in[gi] && !locked_here; // R21
      // A packet met with NAK was never taken, so its PID must not land in the status.
      assign pkt_here      = pkt.done && ep_hit(pkt.ep, gi) && !halt_reg && !nak_here; // R19
      assign read_here     = read_done && ep_hit(read_ep, gi);
      assign written_here  = setup_written && gi == 0;

      // Setup_clobbered_flag is only meaningful on the OUT side, where setup data lands.
      assign clob_set = setup_here && gi == 0 && (setup_reg || writing_reg) && lock_reg && !halt_reg;
      assign clob_clr = read_here && !writing_reg; // R10

      // Halt: a stall command in the same cycle wins, setup releases it.
      assign halt_next = stall_here ? 1'b1 : (reinit ? 1'b0 : halt_reg); // R5 R7

      // Setup_clobbered_flag flag: a new setup_clobbered_flag beats a clearing read.
      assign clob_next = clob_set || (clob_reg && !clob_clr); // R10

      // Setup data arrives into the primary OUT buffer of endpoint 0.
      assign writing_next = setup_here && gi == 0 ? 1'b1 : (written_here ? 1'b0 : writing_reg);
      assign setup_next   = written_here ? 1'b1 : ((clear_here || reinit) ? 1'b0 : setup_reg); // R12

      // Buffer steering: both sides advance only on double-buffered slots.
      assign cpu_sel_next = reinit ? 1'b0 :
                            ((validate_here || clear_here) && ep_double[gi]) ? ~cpu_sel_reg : // R17
                            cpu_sel_reg;
      assign usb_sel_next = reinit ? 1'b0 :
                            (pkt_here && ep_double[gi]) ? ~usb_sel_reg : usb_sel_reg;

      // Fill state: reinitialise flushes, packets and commands move one buffer each.
      always_comb begin
        full_next = full_reg;
        if (reinit) begin
          full_next = 2'b00; // R9
        end else begin
          if (validate_here) begin
            full_next[cpu_sel_reg] = 1'b1; // R16
          end
          if (clear_here) begin
            full_next[cpu_sel_reg] = 1'b0; // R18
          end
          if (pkt_here) begin
            full_next[usb_sel_reg] = !direction_in[gi]; // R19
          end
          if (written_here) begin
            full_next[0] = 1'b1;
          end
        end
      end

      // Toggle: restart at DATA0, OUT records the PID, IN flips after a send.
      assign toggle_next = (reinit || written_here) ? 1'b0 :
                           !pkt_here               ? toggle_reg :
                           direction_in[gi]        ? ~toggle_reg : pkt.pid; // R15

      // State flops.
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          halt_reg    <= 1'b0; // R4
          full_reg    <= 2'b00;
          toggle_reg  <= 1'b0;
          clob_reg    <= 1'b0;
          setup_reg   <= 1'b0;
          cpu_sel_reg <= 1'b0;
          usb_sel_reg <= 1'b0;
          writing_reg <= 1'b0;
        end else begin
          halt_reg    <= halt_next;
          full_reg    <= full_next;
          toggle_reg  <= toggle_next;
          clob_reg    <= clob_next;
          setup_reg   <= setup_next;
          cpu_sel_reg <= cpu_sel_next;
          usb_sel_reg <= usb_sel_next;
          writing_reg <= writing_next;
        end
      end

      // Status byte layout, read-only to the microcontroller.
      always_comb begin
        status_byte[gi]                    = `UESC_STATUS_RST; // R4
        status_byte[gi][`UESC_BIT_HALT]    = halt_reg;
        status_byte[gi][`UESC_BIT_FULL1]   = full_reg[1]; // R14
        status_byte[gi][`UESC_BIT_FULL0]   = full_reg[0]; // R14
        status_byte[gi][`UESC_BIT_TOGGLE]  = toggle_reg; // R15
        status_byte[gi][`UESC_BIT_CLOBBER] = clob_reg; // R10
        status_byte[gi][`UESC_BIT_SETUP]   = setup_reg; // R12
        status_byte[gi][`UESC_BIT_HOST_CPU_BUFFER_SELECT]  = cpu_sel_reg; // R13
        status_byte[gi][`UESC_BIT_RSVD]    = 1'b0; // R22
      end

      // Answers to the serial engine: OUT refuses while the USB-side buffer is full.
      assign nak_here       = direction_in[gi] ? !full_reg[usb_sel_reg] : full_reg[usb_sel_reg]; // R19
      assign ep_nak[gi]     = nak_here;
      assign ep_stalled[gi] = halt_reg;
      assign ep_int_clr[gi] = read_here; // R3
    end
  endgenerate

endmodule

// file: dv/uesc_ep_status_props.sv
// Port checker for the endpoint status block.
`timescale 1ns/1ns

module uesc_ep_status_props (
  // Clock and reset.
  input wire logic                sys_clk,
  input wire logic                rst_b,
  // Command port.
  input wire logic                cmd_strobe,
  input wire logic [7:0]          cmd_code,
  input wire logic                data_rd,
  input wire logic [7:0]          rd_data,
  input wire logic                rd_pending,
  // Configuration and serial events.
  input wire logic [15:0]         ep_double,
  input wire logic [15:0]         ep_is_in,
  input wire logic                setup_token,
  input wire logic                setup_written,
  input wire uesc_pkg::uesc_pkt_t pkt,
  // Answers.
  input wire logic [15:0]         ep_nak,
  input wire logic [15:0]         ep_stalled,
  input wire logic [15:0]         ep_int_clr,
  input wire logic                setup_locked
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // ==========================================================
  // Command classes seen at the port.
  wire is_stall   = cmd_strobe && cmd_code[7:4] == 4'h4;
  wire is_unstall = cmd_strobe && cmd_code[7:4] == 4'h8;
  wire is_rd      = cmd_strobe && (cmd_code[7:4] == 4'h5 || cmd_code[7:4] == 4'hD);
  wire out_pkt    = pkt.done && pkt.ep > 4'h1 && !ep_is_in[pkt.ep] && !ep_double[pkt.ep];

  // ==========================================================
  // Properties.
  stall_sets_a: assert property (is_stall |=> ep_stalled[$past(cmd_code[3:0])])
    else $error("stall command did not halt the endpoint");
  unstall_clears_a: assert property (is_unstall |=> !ep_stalled[$past(cmd_code[3:0])])
    else $error("unstall command left the endpoint halted");
  halt_steady_a: assert property (!cmd_strobe && !setup_token |=> $stable(ep_stalled))
    else $error("halt flags moved without a cause");
  setup_unstall_a: assert property (setup_token && !(is_stall && cmd_code[3:1] == 3'h0)
    |=> ep_stalled[1:0] == 2'b00)
    else $error("setup token left a control endpoint halted");
  setup_lock_a: assert property (setup_token |=> setup_locked)
    else $error("setup token did not lock the control buffers");
  ack_unlock_a: assert property (cmd_strobe && cmd_code == 8'hF4 && !setup_token |=> !setup_locked)
    else $error("acknowledge did not unlock the control buffers");
  read_answer_a: assert property (is_rd |=> rd_pending)
    else $error("status byte not offered after a read command");
  pend_drop_a: assert property (data_rd && rd_pending && !is_rd |=> !rd_pending)
    else $error("status byte still pending after its data phase");
  int_clear_a: assert property (ep_int_clr != 16'h0000 |-> $onehot(ep_int_clr) && data_rd && rd_pending)
    else $error("interrupt clear outside a status data phase");
  rsvd_zero_a: assert property (rd_pending |-> !rd_data[0])
    else $error("reserved status bit reads one");
  out_nak_a: assert property (out_pkt && !ep_stalled[pkt.ep] && !cmd_strobe |=> ep_nak[$past(pkt.ep)])
    else $error("full OUT buffer does not refuse packets");
endmodule

bind uesc_ep_status_ctrl uesc_ep_status_props chk_u (
  .sys_clk(sys_clk), .rst_b(rst_b), .cmd_strobe(cmd_strobe), .cmd_code(cmd_code),
  .data_rd(data_rd), .rd_data(rd_data), .rd_pending(rd_pending), .ep_double(ep_double),
  .ep_is_in(ep_is_in), .setup_token(setup_token), .setup_written(setup_written), .pkt(pkt),
  .ep_nak(ep_nak), .ep_stalled(ep_stalled), .ep_int_clr(ep_int_clr), .setup_locked(setup_locked)
);

// file: dv/uesc_mcu_model.sv
// Behavioural system controller driving the command port.
`timescale 1ns/1ns

module uesc_mcu_model (
  // Clock.
  input  wire logic        sys_clk,
  // Command port.
  output logic             cmd_strobe,
  output logic [7:0]       cmd_code,
  output logic             data_rd,
  // Answers.
  input  wire logic [7:0]  rd_data,
  input  wire logic [15:0] ep_int_clr
);
  // Idle port at time zero.
  initial begin
    cmd_strobe = 1'b0;
    cmd_code   = 8'h00;
    data_rd    = 1'b0;
  end

  // One command phase; the code is inverted afterwards so a stale byte never looks live.
  task automatic cmd(input logic [7:0] code);
    @(posedge sys_clk) #1;
    cmd_strobe = 1'b1;
    cmd_code   = code;
    @(posedge sys_clk) #1;
    cmd_strobe = 1'b0;
    cmd_code   = ~code;
  endtask

  // Command followed by its one-byte data phase.
  task automatic rd(input logic [7:0] code, output logic [7:0] val, output logic [15:0] clr);
    cmd(code);
    data_rd = 1'b1;
    #2;
    val = rd_data;
    clr = ep_int_clr;
    @(posedge sys_clk) #1;
    data_rd = 1'b0;
  endtask

  // Firmware drops a clobbered setup and acknowledges only a clean one.
  task automatic ack_setup(output logic ok);
    logic [7:0]  s;
    logic [15:0] c;
    rd(8'h50, s, c);
    ok = !s[3];
    if (ok) cmd(8'hF4);
  endtask
endmodule

// file: dv/tb_top.sv
// Self-checking bench for the endpoint status block.
`timescale 1ns/1ns

module tb_top;
  logic                sys_clk;
  logic                rst_b;
  logic                cmd_strobe;
  logic [7:0]          cmd_code;
  logic                data_rd;
  logic [7:0]          rd_data;
  logic                rd_pending;
  logic                setup_token;
  logic                setup_written;
  logic                ok;
  logic [7:0]          v;
  logic [15:0]         c;
  logic [15:0]         ep_double;
  logic [15:0]         ep_is_in;
  logic [15:0]         ep_nak;
  logic [15:0]         ep_stalled;
  logic [15:0]         ep_int_clr;
  logic                setup_locked;
  uesc_pkg::uesc_pkt_t pkt;
  int                  err_count = 0;
  int                  num_checks = 0;

  // ==========================================================
  // Design and controller model; ep4 OUT and ep5 IN are double buffered.
  uesc_ep_status_ctrl dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .cmd_strobe(cmd_strobe), .cmd_code(cmd_code),
    .data_rd(data_rd), .rd_data(rd_data), .rd_pending(rd_pending), .ep_double(ep_double), .ep_is_in(ep_is_in),
    .setup_token(setup_token), .setup_written(setup_written), .pkt(pkt), .ep_nak(ep_nak),
    .ep_stalled(ep_stalled), .ep_int_clr(ep_int_clr), .setup_locked(setup_locked));
  uesc_mcu_model mcu_u (.sys_clk(sys_clk), .cmd_strobe(cmd_strobe), .cmd_code(cmd_code), .data_rd(data_rd),
    .rd_data(rd_data), .ep_int_clr(ep_int_clr));

  // Free-running clock, 4 ns period.
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Tasks.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Status copy read; it must never clear an interrupt.
  task automatic st(input logic [3:0] ep, input logic [7:0] exp);
    mcu_u.rd({4'hD, ep}, v, c);
    chk({8'h00, v}, {8'h00, exp});
    chk(c, 16'h0000);
  endtask

  // One-cycle serial engine event.
  task automatic ev(input logic s, input logic w, input logic [3:0] ep, input logic d, input logic pid);
    @(posedge sys_clk) #1;
    setup_token   = s;
    setup_written = w;
    pkt           = '{d, ep, pid};
    @(posedge sys_clk) #1;
    setup_token   = 1'b0;
    setup_written = 1'b0;
    pkt.done      = 1'b0;
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog sized well beyond the few hundred cycles the tests need.
  initial begin
    #60000;
    err_count++;
    $display("ERROR %0t watchdog expired", $time);
    end_of_test();
  end

  // ==========================================================
  // Test sequence.
  initial begin
    rst_b         = 1'b0;
    setup_token   = 1'b0;
    setup_written = 1'b0;
    pkt           = '{1'b0, 4'h0, 1'b0};
    ep_double     = 16'h0030;
    ep_is_in      = 16'h00A9;  // Bits 1:0 are fixed inside the block, so they are deliberately reversed here.
    repeat (4) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    for (int i = 0; i < 16; i++) st(i[3:0], 8'h00);
    chk(ep_nak, 16'h00AA);
    for (int i = 0; i < 16; i++) begin
      mcu_u.cmd({4'h4, i[3:0]});
      st(i[3:0], 8'h80);
      chk(ep_stalled, 16'h0001 << i);
      mcu_u.cmd({4'h8, i[3:0]});
      st(i[3:0], 8'h00);
    end
    // Single OUT: full buffer refuses a second packet until cleared.
    ev(1'b0, 1'b0, 4'h2, 1'b1, 1'b1);
    st(4'h2, 8'h30);
    // The refused DATA0 packet must leave the recorded DATA1 alone.
    ev(1'b0, 1'b0, 4'h2, 1'b1, 1'b0);
    mcu_u.rd(8'h52, v, c);
    chk({8'h00, v}, 16'h0030);
    chk(c, 16'h0004);
    chk(ep_nak, 16'h00AE);
    mcu_u.cmd(8'h72);
    st(4'h2, 8'h10);
    // Single IN, then a stall and unstall flushes it back to DATA0.
    mcu_u.cmd(8'h63);
    st(4'h3, 8'h20);
    ev(1'b0, 1'b0, 4'h3, 1'b1, 1'b0);
    st(4'h3, 8'h10);
    mcu_u.cmd(8'h63);
    mcu_u.cmd(8'h43);
    mcu_u.cmd(8'h83);
    st(4'h3, 8'h00);
    chk(ep_nak, 16'h00AA);
    // Double buffering swaps the controller side on validate and clear.
    mcu_u.cmd(8'h65);
    st(4'h5, 8'h22);
    mcu_u.cmd(8'h65);
    st(4'h5, 8'h60);
    ev(1'b0, 1'b0, 4'h4, 1'b1, 1'b0);
    st(4'h4, 8'h20);
    mcu_u.cmd(8'h74);
    st(4'h4, 8'h02);
    mcu_u.cmd(8'h64);
    mcu_u.cmd(8'h71);
    st(4'h4, 8'h02);
    st(4'h1, 8'h00);
    // Setup on halted control endpoints, then an setup_clobbered_flag before acknowledge.
    mcu_u.cmd(8'h40);
    mcu_u.cmd(8'h41);
    ev(1'b1, 1'b0, 4'h0, 1'b0, 1'b0);
    chk(ep_stalled, 16'h0000);
    ev(1'b0, 1'b1, 4'h0, 1'b0, 1'b0);
    st(4'h0, 8'h24);
    mcu_u.cmd(8'h61);
    st(4'h1, 8'h00);
    ev(1'b1, 1'b0, 4'h0, 1'b0, 1'b0);
    ev(1'b0, 1'b1, 4'h0, 1'b0, 1'b0);
    st(4'h0, 8'h2C);
    mcu_u.ack_setup(ok);
    chk({15'h0, ok}, 16'h0000);
    st(4'h0, 8'h24);
    mcu_u.ack_setup(ok);
    chk({15'h0, ok}, 16'h0001);
    mcu_u.cmd(8'h61);
    st(4'h1, 8'h20);
    mcu_u.cmd(8'h40);
    chk(ep_stalled, 16'h0001);
    end_of_test();
  end
endmodule
